// ===== ppd_defs.svh
// Purpose: address map, function codes and sizes of the packed process data map
// Assumes: register addresses are 16-bit, input and output windows are 512 registers each
// Notes: definitions only
`ifndef PPD_DEFS_SVH
`define PPD_DEFS_SVH

`define PPD_IN_LAST 16'h01ff
`define PPD_OUT_BASE 16'h0800
`define PPD_OUT_LAST 16'h09ff
`define PPD_OFS_BASE 16'h2b00
`define PPD_OFS_LAST 16'h2b7f

`define PPD_FC_RD_COILS 8'h01
`define PPD_FC_RD_DISCR 8'h02
`define PPD_FC_RD_HOLD 8'h03
`define PPD_FC_RD_INPUT 8'h04
`define PPD_FC_WR_COIL 8'h05
`define PPD_FC_WR_SINGLE 8'h06
`define PPD_FC_WR_COILS 8'h0f
`define PPD_FC_WR_MULTI 8'h10
`define PPD_FC_MASK_WR 8'h16
`define PPD_FC_RD_WR 8'h17

`define PPD_EXC_NONE 8'h00
`define PPD_EXC_FUNC 8'h01
`define PPD_EXC_ADDR 8'h02

`define PPD_WIN_BYTES 12'h400
`define PPD_MAX_MODS 7'h40

`endif

// ===== ppd_pkg.sv
// Purpose: types shared by the packed process data map
// Assumes: nothing beyond the defs header
// Notes: register requests arrive one register at a time
`default_nettype none
package ppd_pkg;
  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] and_mask;
    logic [15:0] or_mask;
  } ppd_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0] exc;
  } ppd_rsp_t;

  typedef struct packed {
    logic [6:0] in_len;
    logic [6:0] out_len;
  } ppd_entry_t;
endpackage
`default_nettype wire

// ===== ppd_layout.sv
// Purpose: assigns packed byte offsets to modules in station order
// Assumes: entries arrive one per cycle in physical order after a clear
// Notes: even-length data start on a register boundary, odd-length data pack by byte
`include "ppd_defs.svh"
`default_nettype none
module ppd_layout (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic lay_clear,
  input wire logic ent_valid,
  input wire ppd_pkg::ppd_entry_t ent,
  output logic [6:0] mod_count,
  output logic [10:0] in_next,
  output logic [10:0] out_next,
  output logic [63:0][10:0] in_off,
  output logic [63:0][10:0] out_off,
  output logic [63:0][6:0] in_len,
  output logic [63:0][6:0] out_len,
  output logic mark_valid,
  output logic [10:0] mark_start,
  output logic [6:0] mark_len
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [10:0] ppd_align(input logic [10:0] off, input logic [6:0] len);
    ppd_align = (len[0] || !off[0]) ? off : 11'(off + 11'h001);
  endfunction

  function automatic logic ppd_fits(input logic [10:0] start, input logic [6:0] len);
    ppd_fits = (12'({1'b0, start}) + 12'({5'h00, len})) <= `PPD_WIN_BYTES;
  endfunction

  logic take;
  logic [10:0] in_start;
  logic [10:0] out_start;
  logic in_ok;
  logic out_ok;
  logic [6:0] next_in_len;
  logic [6:0] next_out_len;

  assign take = ent_valid && !lay_clear && (mod_count < `PPD_MAX_MODS);
  assign in_start = ppd_align(in_next, ent.in_len);
  assign out_start = ppd_align(out_next, ent.out_len);
  assign in_ok = ppd_fits(in_start, ent.in_len);
  assign out_ok = ppd_fits(out_start, ent.out_len);
  // data that would overrun a window is dropped rather than wrapped
  assign next_in_len = in_ok ? ent.in_len : 7'h00;
  assign next_out_len = out_ok ? ent.out_len : 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mod_count <= 7'h00;
      in_next <= 11'h000;
      out_next <= 11'h000;
      in_off <= '0;
      out_off <= '0;
      in_len <= '0;
      out_len <= '0;
      mark_valid <= 1'b0;
      mark_start <= 11'h000;
      mark_len <= 7'h00;
    end
    else if (lay_clear)
    begin
      mod_count <= 7'h00;
      in_next <= 11'h000;
      out_next <= 11'h000;
      in_off <= '0;
      out_off <= '0;
      in_len <= '0;
      out_len <= '0;
      mark_valid <= 1'b0;
    end
    else
    begin
      mark_valid <= take;
      if (take)
      begin
        in_off[mod_count[5:0]] <= in_start;
        out_off[mod_count[5:0]] <= out_start;
        in_len[mod_count[5:0]] <= next_in_len;
        out_len[mod_count[5:0]] <= next_out_len;
        mod_count <= 7'(mod_count + 7'h01);
        if (in_ok)
          in_next <= 11'(in_start + {4'h0, ent.in_len});
        if (out_ok)
          out_next <= 11'(out_start + {4'h0, ent.out_len});
        mark_start <= out_start;
        mark_len <= next_out_len;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_clear_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    lay_clear |=> (in_next == 11'h000 && out_next == 11'h000 && mod_count == 7'h00))
    else $error("layout did not restart at window start");

  a_byte_pack: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && ent.in_len == 7'h01 && in_ok |=> in_next == 11'($past(in_next) + 11'h001))
    else $error("one-byte module not packed into next byte");

  a_word_align: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && !ent.in_len[0] && ent.in_len != 7'h00 |=> !in_off[$past(mod_count[5:0])][0])
    else $error("word data not on a register boundary");
endmodule
`default_nettype wire

// ===== ppd_map.sv
// Purpose: packed input and output process data windows with a module offset table
// Assumes: station-side ports run on clk_sys; block-access codes are split per register
// Notes: one request per cycle, answer one cycle later
//
// Functional notes
// - input data readable as 512 registers at 0x0000 to 0x01ff.
// - output data readable and writable as 512 registers at 0x0800 to 0x09ff.
// - every window register is readable by register read codes without an access error; input registers refuse writes.
// - input registers holding no module data read as zero.
// - unused output registers read zero and ignore writes.
// - module data packed at byte granularity in consecutive bytes, except even-length data start on a register boundary.
// - modules get positions in physical order from the start of each window.
// - module start offsets readable at registers 0x2b00 to 0x2b7f.
// - one-byte module takes low byte, the next one-byte module the high byte.
// - bit address shifts right one digit to give the register, low digit selects the bit.
// - register read, write, masked write and read/write codes are accepted.
`include "ppd_defs.svh"
`default_nettype none
module ppd_map (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic lay_clear,
  input wire logic lay_valid,
  input wire ppd_pkg::ppd_entry_t lay_entry,
  input wire logic stn_in_valid,
  input wire logic [5:0] stn_in_slot,
  input wire logic [5:0] stn_in_idx,
  input wire logic [7:0] stn_in_data,
  input wire logic [5:0] stn_out_slot,
  input wire logic [5:0] stn_out_idx,
  output logic [7:0] stn_out_data,
  input wire logic req_valid,
  input wire ppd_pkg::ppd_req_t req,
  output logic rsp_valid,
  output ppd_pkg::ppd_rsp_t rsp
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [10:0] ppd_pos(input logic [10:0] off, input logic [5:0] idx);
    ppd_pos = 11'(off + {5'h00, idx});
  endfunction

  logic [6:0] mod_count;
  logic [10:0] in_next;
  logic [10:0] out_next;
  logic [63:0][10:0] in_off;
  logic [63:0][10:0] out_off;
  logic [63:0][6:0] in_len;
  logic [63:0][6:0] out_len;
  logic mark_valid;
  logic [10:0] mark_start;
  logic [6:0] mark_len;

  ppd_layout u_layout (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .lay_clear(lay_clear),
    .ent_valid(lay_valid),
    .ent(lay_entry),
    .mod_count(mod_count),
    .in_next(in_next),
    .out_next(out_next),
    .in_off(in_off),
    .out_off(out_off),
    .in_len(in_len),
    .out_len(out_len),
    .mark_valid(mark_valid),
    .mark_start(mark_start),
    .mark_len(mark_len)
  );

  logic [7:0] in_mem [1024];
  logic [7:0] out_mem [1024];
  logic [1023:0] out_used;

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  logic [7:0] fc;
  logic bit_fc;
  logic [15:0] reg_addr;
  logic [3:0] bit_idx;
  logic in_win;
  logic out_win;
  logic ofs_win;
  logic [9:0] wbl;
  logic [9:0] wbh;
  logic [15:0] in_word;
  logic [15:0] out_word;
  logic [5:0] ofs_mod;
  logic [15:0] ofs_word;
  logic [15:0] rd_word;
  logic rd_bit;
  logic fc_rd;
  logic fc_wr;
  logic fc_known;
  logic addr_ok;
  logic [7:0] exc;
  logic [15:0] mask_word;
  logic [15:0] bit_word;
  logic [15:0] new_word;
  logic do_wr;

  assign fc = req.func;
  assign bit_fc = fc == `PPD_FC_RD_COILS || fc == `PPD_FC_RD_DISCR ||
                  fc == `PPD_FC_WR_COIL || fc == `PPD_FC_WR_COILS;
  assign reg_addr = bit_fc ? {4'h0, req.addr[15:4]} : req.addr;
  assign bit_idx = req.addr[3:0];
  assign in_win = reg_addr <= `PPD_IN_LAST;
  assign out_win = reg_addr >= `PPD_OUT_BASE && reg_addr <= `PPD_OUT_LAST;
  assign ofs_win = reg_addr >= `PPD_OFS_BASE && reg_addr <= `PPD_OFS_LAST;
  assign wbl = {reg_addr[8:0], 1'b0};
  assign wbh = {reg_addr[8:0], 1'b1};
  assign in_word = {in_mem[wbh], in_mem[wbl]};
  assign out_word = {out_mem[wbh], out_mem[wbl]};
  // two registers per module: even holds the input byte offset, odd the output byte offset
  assign ofs_mod = reg_addr[6:1];
  assign ofs_word = ({1'b0, ofs_mod} >= mod_count) ? 16'h0000 :
                    reg_addr[0] ? {5'h00, out_off[ofs_mod]} : {5'h00, in_off[ofs_mod]};
  assign rd_word = in_win ? in_word : out_win ? out_word : ofs_win ? ofs_word : 16'h0000;
  assign rd_bit = rd_word[bit_idx];

  assign fc_rd = fc == `PPD_FC_RD_COILS || fc == `PPD_FC_RD_DISCR ||
                 fc == `PPD_FC_RD_HOLD || fc == `PPD_FC_RD_INPUT;
  // the read half of a combined read/write arrives as its own input-register read
  assign fc_wr = fc == `PPD_FC_WR_COIL || fc == `PPD_FC_WR_SINGLE || fc == `PPD_FC_WR_COILS ||
                 fc == `PPD_FC_WR_MULTI || fc == `PPD_FC_MASK_WR || fc == `PPD_FC_RD_WR;
  assign fc_known = fc_rd || fc_wr;
  assign addr_ok = (fc == `PPD_FC_RD_DISCR) ? in_win :
                   bit_fc ? out_win :
                   fc_rd ? (in_win || out_win || ofs_win) : out_win;
  assign exc = !fc_known ? `PPD_EXC_FUNC : !addr_ok ? `PPD_EXC_ADDR : `PPD_EXC_NONE;

  assign mask_word = (out_word & req.and_mask) | (req.or_mask & ~req.and_mask);
  assign bit_word = req.wdata[0] ? (out_word | (16'h0001 << bit_idx)) :
                    (out_word & ~(16'h0001 << bit_idx));
  assign new_word = (fc == `PPD_FC_MASK_WR) ? mask_word : bit_fc ? bit_word : req.wdata;
  assign do_wr = req_valid && fc_wr && addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // station side
  logic [10:0] stn_in_pos;
  logic stn_in_ok;
  logic [10:0] stn_out_pos;
  logic stn_out_ok;

  assign stn_in_pos = ppd_pos(in_off[stn_in_slot], stn_in_idx);
  assign stn_in_ok = stn_in_valid && ({1'b0, stn_in_idx} < in_len[stn_in_slot]);
  assign stn_out_pos = ppd_pos(out_off[stn_out_slot], stn_out_idx);
  assign stn_out_ok = {1'b0, stn_out_idx} < out_len[stn_out_slot];

  ////////////////////////////////////////////////////////////////////////////
  // a new layout wipes both windows, so gaps left by alignment read as zero
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 1024; i++)
      begin
        in_mem[i] <= 8'h00;
        out_mem[i] <= 8'h00;
      end
      out_used <= '0;
    end
    else if (lay_clear)
    begin
      for (int i = 0; i < 1024; i++)
      begin
        in_mem[i] <= 8'h00;
        out_mem[i] <= 8'h00;
      end
      out_used <= '0;
    end
    else
    begin
      if (stn_in_ok)
        in_mem[stn_in_pos[9:0]] <= stn_in_data;
      if (mark_valid)
      begin
        for (int i = 0; i < 1024; i++)
        begin
          if (i >= int'(mark_start) && i < int'(mark_start) + int'(mark_len))
            out_used[i] <= 1'b1;
        end
      end
      if (do_wr && out_used[wbl])
        out_mem[wbl] <= new_word[7:0];
      if (do_wr && out_used[wbh])
        out_mem[wbh] <= new_word[15:8];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      stn_out_data <= 8'h00;
    end
    else
    begin
      rsp_valid <= req_valid;
      rsp.exc <= exc;
      rsp.data <= (exc != `PPD_EXC_NONE || !fc_rd) ? 16'h0000 :
                  bit_fc ? {15'h0000, rd_bit} : rd_word;
      stn_out_data <= stn_out_ok ? out_mem[stn_out_pos[9:0]] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] past_out_word;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      past_out_word <= 16'h0000;
    else
      past_out_word <= out_word;
  end

  a_rsp_latency: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid |=> rsp_valid ##1 !rsp_valid || $past(req_valid))
    else $error("answer not one cycle after request");

  a_window_no_error: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid && fc == `PPD_FC_RD_HOLD && (in_win || out_win) |=> rsp.exc == `PPD_EXC_NONE)
    else $error("window read raised an exception");

  a_unused_in_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid && !lay_clear && fc == `PPD_FC_RD_INPUT && in_win && {1'b0, wbl} >= in_next
    |=> rsp.data == 16'h0000)
    else $error("unused input register read nonzero");

  a_unused_out_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
    do_wr && !lay_clear && !mark_valid && !out_used[wbl] && !out_used[wbh]
    |=> $past(out_word) == {out_mem[$past(wbh)], out_mem[$past(wbl)]})
    else $error("write to unused output register changed it");

  a_unused_out_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid && !lay_clear && fc == `PPD_FC_RD_HOLD && out_win && {1'b0, wbl} >= out_next
    |=> rsp.data == 16'h0000)
    else $error("unused output register read nonzero");

  a_out_readback: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid && fc == `PPD_FC_RD_HOLD && out_win |=> rsp.data == past_out_word)
    else $error("output window read wrong word");

  a_mask_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    do_wr && !lay_clear && fc == `PPD_FC_MASK_WR && out_used[wbl] && out_used[wbh]
    |=> {out_mem[$past(wbh)], out_mem[$past(wbl)]} == $past(mask_word))
    else $error("masked write result wrong");

  a_bit_address: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid && fc == `PPD_FC_RD_DISCR && in_win
    |=> rsp.data == {15'h0000, $past(in_word[bit_idx])})
    else $error("discrete input bit not taken from shifted address");

  a_bad_function: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid && !fc_known |=> rsp.exc == `PPD_EXC_FUNC && rsp.data == 16'h0000)
    else $error("unknown function code not refused");

  a_input_readonly: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid && fc == `PPD_FC_WR_SINGLE && in_win |=> rsp.exc == `PPD_EXC_ADDR)
    else $error("write to input window not refused");
endmodule
`default_nettype wire

// ===== ppd_master.sv
// Purpose: register master model that issues one request per call
// Assumes: the answer comes within four edges of the taking edge
// Notes: released request fields are inverted so stale values never match
`include "ppd_defs.svh"
`default_nettype none
module ppd_master (
  input wire logic clk_sys,
  output logic req_valid,
  output ppd_pkg::ppd_req_t req,
  input wire logic rsp_valid,
  input wire ppd_pkg::ppd_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // bit codes carry {register, bit} in the address; one register per request
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w, input logic [15:0] am,
                      input logic [15:0] om, output ppd_pkg::ppd_rsp_t r);
    bit got;
    got = 1'b0;
    r = '1;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= {f, a, w, am, om};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req <= ~req;
    repeat (4)
    begin
      @(posedge clk_sys);
      if (!got && rsp_valid === 1'b1)
      begin
        r = rsp;
        got = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the packed process data map
// Assumes: master model drives the register port, bench drives layout and station
// Notes: station layout mirrors a paired byte arrangement
`include "ppd_defs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic lay_clear = 1'b0;
  logic lay_valid = 1'b0;
  ppd_pkg::ppd_entry_t lay_entry = '0;
  logic stn_in_valid = 1'b0;
  logic [5:0] stn_in_slot = '0;
  logic [5:0] stn_in_idx = '0;
  logic [7:0] stn_in_data = '0;
  logic [5:0] stn_out_slot = '0;
  logic [5:0] stn_out_idx = '0;
  logic [7:0] stn_out_data;
  logic req_valid;
  ppd_pkg::ppd_req_t req;
  logic rsp_valid;
  ppd_pkg::ppd_rsp_t rsp;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  ppd_map uut (.clk_sys(clk_sys), .nrst(nrst), .lay_clear(lay_clear), .lay_valid(lay_valid),
    .lay_entry(lay_entry), .stn_in_valid(stn_in_valid), .stn_in_slot(stn_in_slot), .stn_in_idx(stn_in_idx),
    .stn_in_data(stn_in_data), .stn_out_slot(stn_out_slot), .stn_out_idx(stn_out_idx),
    .stn_out_data(stn_out_data), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  ppd_master mst (.clk_sys(clk_sys), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // writes answer with no data, so only their code is compared
  task automatic acc(input string what, input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                     input logic [15:0] d, input logic [7:0] e, input logic [15:0] am = '0,
                     input logic [15:0] om = '0);
    ppd_pkg::ppd_rsp_t r;
    logic wr;
    wr = f inside {8'h05, 8'h06, 8'h0f, 8'h10, 8'h16, 8'h17};
    mst.xfer(f, a, w, am, om, r);
    chk(what, wr ? {16'h0, e} : {d, e}, wr ? {16'h0, r.exc} : r);
  endtask
  task automatic rdout(input logic [5:0] s, input logic [5:0] i, input logic [7:0] exp);
    @(posedge clk_sys);
    stn_out_slot <= s;
    stn_out_idx <= i;
    repeat (2) @(posedge clk_sys);
    chk("station out", {16'h0, exp}, {16'h0, stn_out_data});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("reset outputs", 24'h0, {7'h0, rsp_valid, stn_out_data, 8'h0} | {rsp[23:8], 8'h0});
    acc("empty input", 8'h04, 16'h0000, 16'h0, 16'h0, `PPD_EXC_NONE);
    acc("last input", 8'h04, `PPD_IN_LAST, 16'h0, 16'h0, `PPD_EXC_NONE);
    $display("test reset done");
  endtask
  task automatic t_layout();
    // byte modules placed next to each other so they share one register
    logic [13:0] ents [6] = '{{7'd0, 7'd8}, {7'd8, 7'd0}, {7'd1, 7'd0}, {7'd1, 7'd0},
                              {7'd2, 7'd0}, {7'd2, 7'd0}};
    logic [15:0] ofs [7] = '{16'h0, 16'h0, 16'h8, 16'h9, 16'ha, 16'hc, 16'h0};
    logic [15:0] oexp;
    @(posedge clk_sys);
    lay_clear <= 1'b1;
    @(posedge clk_sys);
    lay_clear <= 1'b0;
    foreach (ents[k])
    begin
      lay_valid <= 1'b1;
      lay_entry <= ents[k];
      @(posedge clk_sys);
    end
    lay_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 7; k++)
    begin
      acc("in offset", 8'h03, `PPD_OFS_BASE + 16'(2 * k), 16'h0, ofs[k], `PPD_EXC_NONE);
      // only the first module carries output data; slot 6 lies beyond the six fitted modules
      oexp = (k % 6 == 0) ? 16'h0 : 16'h8;
      acc("out offset", 8'h03, `PPD_OFS_BASE + 16'(2 * k + 1), 16'h0, oexp, `PPD_EXC_NONE);
    end
    $display("test layout done");
  endtask
  task automatic t_inputs();
    logic [19:0] wr [7] = '{{6'd1, 6'd0, 8'h11}, {6'd1, 6'd1, 8'h22}, {6'd2, 6'd0, 8'ha1}, {6'd3, 6'd0, 8'hb2},
                            {6'd4, 6'd0, 8'hc3}, {6'd4, 6'd1, 8'hd4}, {6'd2, 6'd1, 8'hee}};
    foreach (wr[k])
    begin
      @(posedge clk_sys);
      stn_in_valid <= 1'b1;
      {stn_in_slot, stn_in_idx, stn_in_data} <= wr[k];
    end
    @(posedge clk_sys);
    stn_in_valid <= 1'b0;
    acc("word module", 8'h04, 16'h0000, 16'h0, 16'h2211, `PPD_EXC_NONE);
    acc("byte pair", 8'h04, 16'h0004, 16'h0, 16'hb2a1, `PPD_EXC_NONE);
    acc("two byte", 8'h04, 16'h0005, 16'h0, 16'hd4c3, `PPD_EXC_NONE);
    acc("gap", 8'h04, 16'h0007, 16'h0, 16'h0, `PPD_EXC_NONE);
    acc("input write", 8'h06, 16'h0000, 16'h0001, 16'h0, `PPD_EXC_ADDR);
    acc("input kept", 8'h04, 16'h0000, 16'h0, 16'h2211, `PPD_EXC_NONE);
    acc("past input", 8'h03, 16'h0200, 16'h0, 16'h0, `PPD_EXC_ADDR);
    $display("test inputs done");
  endtask
  task automatic t_outputs();
    acc("out write", 8'h06, `PPD_OUT_BASE, 16'h1234, 16'h0, `PPD_EXC_NONE);
    rdout(6'd0, 6'd0, 8'h34);
    rdout(6'd0, 6'd1, 8'h12);
    acc("out read", 8'h03, `PPD_OUT_BASE, 16'h0, 16'h1234, `PPD_EXC_NONE);
    acc("unused write", 8'h06, 16'h0804, 16'hffff, 16'h0, `PPD_EXC_NONE);
    acc("unused read", 8'h03, 16'h0804, 16'h0, 16'h0, `PPD_EXC_NONE);
    acc("last write", 8'h06, `PPD_OUT_LAST, 16'hffff, 16'h0, `PPD_EXC_NONE);
    acc("last read", 8'h03, `PPD_OUT_LAST, 16'h0, 16'h0, `PPD_EXC_NONE);
    $display("test outputs done");
  endtask
  task automatic t_codes();
    acc("multi write", 8'h10, 16'h0801, 16'haaaa, 16'h0, `PPD_EXC_NONE);
    acc("mask write", 8'h16, 16'h0801, 16'h0, 16'h0, `PPD_EXC_NONE, 16'hff00, 16'h0055);
    acc("mask result", 8'h03, 16'h0801, 16'h0, 16'haa55, `PPD_EXC_NONE);
    acc("rw write", 8'h17, 16'h0802, 16'h5a5a, 16'h0, `PPD_EXC_NONE);
    acc("rw read", 8'h04, 16'h0802, 16'h0, 16'h5a5a, `PPD_EXC_NONE);
    acc("bad code", 8'h07, 16'h0000, 16'h0, 16'h0, `PPD_EXC_FUNC);
    acc("coil read", 8'h01, 16'h8002, 16'h0, 16'h1, `PPD_EXC_NONE);
    acc("coil write", 8'h05, 16'h8000, 16'h1, 16'h0, `PPD_EXC_NONE);
    acc("coils write", 8'h0f, 16'h8001, 16'h1, 16'h0, `PPD_EXC_NONE);
    acc("coil result", 8'h03, `PPD_OUT_BASE, 16'h0, 16'h1237, `PPD_EXC_NONE);
    acc("input bit", 8'h02, 16'h0045, 16'h0, 16'h1, `PPD_EXC_NONE);
    $display("test codes done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_layout();
    t_inputs();
    t_outputs();
    t_codes();
    test_done();
  end
  // the run needs a few hundred cycles; this limit is far beyond that
  initial
  begin
    #100us;
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
